// File: src/cbd_top.sv
// bus command decoder: cpu status to memory, i/o and acknowledge strobes
//
// Function
// [R1] status 000 ack, 001 io read, 010 io writes, 10x mem read, 110 mem writes
// [R2] memory read strobe is active low and three-state
// [R3] i/o bus mode: i/o commands assert whatever the address enable level
// [R4] i/o bus mode: peripheral enable and direction go with the i/o command
// [R5] i/o bus mode: memory strobes wait 90 ns after address enable falls
// [R6] system bus mode: no command while address enable is high
// [R7] system bus mode: any command waits 90 ns after address enable falls
// [R8] early write strobes assert one clock before the normal write strobes
// [R9] acknowledge strobe timed exactly like memory read strobe; in i/o bus mode the code asserts it without the address enable wait
// [R10] the interrupting device answers the acknowledge with its vector
// [R11] data enable high enables the transceiver during transfers
// [R12] direction output sets transceiver data flow
// [R13] system bus mode: shared pin is active-high cascade enable on acknowledge
// [R14] a slave controller captures the cascade address while cascade enable is high
// [R15] i/o bus mode: shared pin is active-low peripheral transceiver enable
// [R16] one address latch strobe in every machine cycle
// [R17] command gate low forces every command inactive
// [R18] direction high on write cycles, low on read cycles
// [R19] address enable high floats commands: all in system mode, memory in i/o mode
// [R20] command gate low also drops data enable and peripheral enable
// [R21] floated status inputs read as passive
// [R22] status back to passive ends the cycle on the clock
// [R23] cycle start: latch strobe first, then command and transceiver controls; direction rises with the latch strobe
`timescale 1ns/100ps
`include "cbd_consts.svh"

module cbd_top
  import cbd_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // cpu status pins
  input wire logic cpu_status_bit0_n,
  input wire logic cpu_status_bit1_n,
  input wire logic cpu_status_bit2_n,
  // arbiter and control pins
  input wire logic arbiter_addr_enable_n,
  input wire logic command_gate,
  input wire logic io_bus_mode_select,
  // command strobes, active low, with enables for the three-state drivers
  output logic mem_read_strobe_n,
  output logic mem_write_strobe_n,
  output logic early_mem_write_strobe_n,
  output logic io_read_strobe_n,
  output logic io_write_strobe_n,
  output logic early_io_write_strobe_n,
  output logic irq_acknowledge_strobe_n,
  output logic mem_cmd_oe,
  output logic io_cmd_oe,
  // transceiver and latch controls
  output logic xcvr_data_enable,
  output logic xcvr_direction,
  output logic cascade_or_periph_enable_pin,
  output logic addr_latch_strobe
);

  cbd_state_t r;
  cbd_state_t next_r;

  // filtered view of the pins, from the current state
  logic [2:0] st;
  logic pas;
  logic aen_hi;
  logic gate;
  logic mode;
  logic aen_ok;
  assign st = r.fl[2:0];
  assign pas = (st == `CBD_ST_PASSIVE);
  assign aen_hi = r.fl[`CBD_IX_AEN];
  assign gate = r.fl[`CBD_IX_GATE];
  assign mode = r.fl[`CBD_IX_MODE];
  // counter saturates once address enable has been low long enough
  assign aen_ok = (r.aen_cnt == `CBD_CNT_W'(`CBD_AEN_CYC));

  // next state: synchroniser, phase sequencer and output decode
  always_comb begin
    logic en_e;
    logic en_f;
    logic mem_ok;
    logic io_ok;
    logic io_cyc;
    logic mem_cyc;
    logic rd_mem;
    en_e = 1'b0;
    en_f = 1'b0;
    mem_ok = 1'b0;
    io_ok = 1'b0;
    io_cyc = 1'b0;
    mem_cyc = 1'b0;
    rd_mem = 1'b0;
    next_r = r;
    // pins pass three flops; a bit changes only when the second and third agree
    next_r.ff1 = {io_bus_mode_select, command_gate, arbiter_addr_enable_n,
                  cpu_status_bit2_n, cpu_status_bit1_n, cpu_status_bit0_n};
    next_r.ff2 = r.ff1;
    next_r.ff3 = r.ff2;
    for (int i = 0; i < `CBD_IN_W; i++) begin
      if (r.ff2[i] == r.ff3[i]) begin
        next_r.fl[i] = r.ff3[i];
      end
    end
    // time since address enable fell; any high level restarts the wait
    if (aen_hi) begin
      next_r.aen_cnt = '0;
    end else if (!aen_ok) begin
      next_r.aen_cnt = r.aen_cnt + `CBD_CNT_W'(1);
    end
    // machine cycle sequencer
    unique case (r.ph)
      CBD_IDLE: begin
        if (!pas) begin
          next_r.ph = CBD_LATCH; // R23
          next_r.cyc = st;
        end
      end
      CBD_LATCH: begin
        next_r.ph = pas ? CBD_IDLE : CBD_EARLY; // R23
      end
      CBD_EARLY: begin
        next_r.ph = pas ? CBD_IDLE : CBD_FULL; // R8
      end
      CBD_FULL: begin
        if (pas) begin
          next_r.ph = CBD_IDLE; // R22
        end
      end
    endcase
    // command windows: early covers reads and early writes, full adds late writes
    en_e = gate && (next_r.ph == CBD_EARLY || next_r.ph == CBD_FULL); // R17
    en_f = gate && (next_r.ph == CBD_FULL); // R8
    mem_ok = aen_ok; // R5 R7
    io_ok = mode || aen_ok; // R3 R6 R7
    io_cyc = (next_r.cyc == `CBD_ST_IRQ_ACKNOWLEDGE_STROBE) || (next_r.cyc == `CBD_ST_IORD)
             || (next_r.cyc == `CBD_ST_IOWR);
    rd_mem = (next_r.cyc == `CBD_ST_FETCH) || (next_r.cyc == `CBD_ST_MEMRD);
    mem_cyc = rd_mem || (next_r.cyc == `CBD_ST_MEMWR);
    // status decode into strobes
    next_r.o.mem_read_strobe_n = !(en_e && mem_ok && rd_mem); // R1 R2
    next_r.o.early_mem_write_strobe_n =
      !(en_e && mem_ok && next_r.cyc == `CBD_ST_MEMWR); // R1 R8
    next_r.o.mem_write_strobe_n = !(en_f && mem_ok && next_r.cyc == `CBD_ST_MEMWR); // R1
    next_r.o.io_read_strobe_n = !(en_e && io_ok && next_r.cyc == `CBD_ST_IORD); // R1 R3
    next_r.o.early_io_write_strobe_n =
      !(en_e && io_ok && next_r.cyc == `CBD_ST_IOWR); // R1 R8
    next_r.o.io_write_strobe_n = !(en_f && io_ok && next_r.cyc == `CBD_ST_IOWR); // R1
    // acknowledge shares the read window; it waits on address enable like memory read only in system mode
    next_r.o.irq_acknowledge_strobe_n =
      !(en_e && io_ok && next_r.cyc == `CBD_ST_IRQ_ACKNOWLEDGE_STROBE); // R1 R9
    // drivers float on a high address enable; i/o mode keeps i/o strobes driven
    next_r.o.mem_cmd_oe = !aen_hi; // R19
    next_r.o.io_cmd_oe = mode || !aen_hi; // R19 R6
    // system mode: data enable for every transfer; i/o mode: memory transfers only
    if (mode) begin
      next_r.o.xcvr_data_enable = en_e && mem_ok && mem_cyc; // R11 R20
      next_r.o.cascade_or_periph_enable_pin = !(en_e && io_cyc); // R4 R15 R20
    end else begin
      next_r.o.xcvr_data_enable = en_e && aen_ok && (mem_cyc || io_cyc); // R11 R20
      next_r.o.cascade_or_periph_enable_pin =
        en_e && aen_ok && next_r.cyc == `CBD_ST_IRQ_ACKNOWLEDGE_STROBE; // R13
    end
    // direction is held through the whole cycle so the transceiver never flips mid-transfer
    next_r.o.xcvr_direction = (next_r.ph != CBD_IDLE)
      && (next_r.cyc == `CBD_ST_IOWR || next_r.cyc == `CBD_ST_MEMWR); // R12 R18 R4
    next_r.o.addr_latch_strobe = (next_r.ph == CBD_LATCH); // R16 R23
  end

  // state register; status flops reset high so a floating cpu reads passive
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r.ff1 <= `CBD_IN_RST; // R21
      r.ff2 <= `CBD_IN_RST;
      r.ff3 <= `CBD_IN_RST;
      r.fl <= `CBD_IN_RST;
      r.aen_cnt <= '0;
      r.ph <= CBD_IDLE;
      r.cyc <= `CBD_ST_PASSIVE;
      r.o <= '{mem_read_strobe_n: 1'b1, mem_write_strobe_n: 1'b1,
               early_mem_write_strobe_n: 1'b1, io_read_strobe_n: 1'b1,
               io_write_strobe_n: 1'b1, early_io_write_strobe_n: 1'b1,
               irq_acknowledge_strobe_n: 1'b1, cascade_or_periph_enable_pin: 1'b1,
               default: 1'b0};
    end else begin
      r <= next_r;
    end
  end

  // outputs straight from the state flops
  assign mem_read_strobe_n = r.o.mem_read_strobe_n;
  assign mem_write_strobe_n = r.o.mem_write_strobe_n;
  assign early_mem_write_strobe_n = r.o.early_mem_write_strobe_n;
  assign io_read_strobe_n = r.o.io_read_strobe_n;
  assign io_write_strobe_n = r.o.io_write_strobe_n;
  assign early_io_write_strobe_n = r.o.early_io_write_strobe_n;
  assign irq_acknowledge_strobe_n = r.o.irq_acknowledge_strobe_n;
  assign mem_cmd_oe = r.o.mem_cmd_oe;
  assign io_cmd_oe = r.o.io_cmd_oe;
  assign xcvr_data_enable = r.o.xcvr_data_enable;
  assign xcvr_direction = r.o.xcvr_direction;
  assign cascade_or_periph_enable_pin = r.o.cascade_or_periph_enable_pin;
  assign addr_latch_strobe = r.o.addr_latch_strobe;

  // checks on the decoded outputs
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  logic all_cmd_idle;
  assign all_cmd_idle = mem_read_strobe_n && mem_write_strobe_n
    && early_mem_write_strobe_n && io_read_strobe_n && io_write_strobe_n
    && early_io_write_strobe_n && irq_acknowledge_strobe_n;

  sequence s_start;
    r.ph == CBD_IDLE && !pas;
  endsequence
  sequence s_latch_pulse;
    addr_latch_strobe ##1 !addr_latch_strobe;
  endsequence

  property p_ale_first;
    s_start |=> s_latch_pulse;
  endproperty
  a_ale_first: assert property (p_ale_first) // R16
    else $error("latch strobe missing at cycle start");

  property p_mem_read_decode;
    !mem_read_strobe_n |-> (r.cyc == `CBD_ST_FETCH || r.cyc == `CBD_ST_MEMRD);
  endproperty
  a_mem_read_decode: assert property (p_mem_read_decode) // R1
    else $error("memory read on wrong status");

  property p_io_early_first;
    $fell(io_write_strobe_n) |-> $past(!early_io_write_strobe_n);
  endproperty
  a_io_early_first: assert property (p_io_early_first) // R8
    else $error("io write without early write a cycle before");

  property p_mem_early_first;
    $fell(mem_write_strobe_n) |-> $past(!early_mem_write_strobe_n);
  endproperty
  a_mem_early_first: assert property (p_mem_early_first) // R8
    else $error("memory write without early write a cycle before");

  property p_mem_wait;
    !(mem_read_strobe_n && mem_write_strobe_n && early_mem_write_strobe_n)
      |-> $past(aen_ok);
  endproperty
  a_mem_wait: assert property (p_mem_wait) // R5
    else $error("memory command before address enable delay");

  property p_sys_wait;
    !$past(mode) && !all_cmd_idle |-> $past(aen_ok) && $past(r.aen_cnt, 2) != '0;
  endproperty
  a_sys_wait: assert property (p_sys_wait) // R7
    else $error("system mode command before address enable delay");

  property p_sys_float;
    aen_hi && !mode |=> !mem_cmd_oe && !io_cmd_oe;
  endproperty
  a_sys_float: assert property (p_sys_float) // R6
    else $error("commands driven while address enable high");

  property p_io_any_aen;
    r.ph == CBD_LATCH && !pas && mode && gate && r.cyc == `CBD_ST_IORD
      |=> !io_read_strobe_n && io_cmd_oe && !cascade_or_periph_enable_pin;
  endproperty
  a_io_any_aen: assert property (p_io_any_aen) // R3
    else $error("io read not asserted in io bus mode");

  property p_gate_off;
    !gate |=> all_cmd_idle && !xcvr_data_enable
      && (cascade_or_periph_enable_pin == $past(mode));
  endproperty
  a_gate_off: assert property (p_gate_off) // R17
    else $error("outputs active while command gate low");

  property p_cascade;
    !$past(mode) && cascade_or_periph_enable_pin |-> r.cyc == `CBD_ST_IRQ_ACKNOWLEDGE_STROBE
      && !irq_acknowledge_strobe_n;
  endproperty
  a_cascade: assert property (p_cascade) // R13
    else $error("cascade enable outside acknowledge");

  property p_dir;
    xcvr_direction |-> (r.cyc == `CBD_ST_IOWR || r.cyc == `CBD_ST_MEMWR);
  endproperty
  a_dir: assert property (p_dir) // R18
    else $error("direction high on a read cycle");

  property p_end;
    r.ph != CBD_IDLE && pas |=> r.ph == CBD_IDLE && all_cmd_idle;
  endproperty
  a_end: assert property (p_end) // R22
    else $error("cycle not ended on passive status");

  // read-type strobes share one window, so acknowledge and memory read line up once aen_ok holds
  sequence s_ack_start;
    r.ph == CBD_IDLE && st == `CBD_ST_IRQ_ACKNOWLEDGE_STROBE;
  endsequence

  sequence s_read_start;
    r.ph == CBD_IDLE && (st == `CBD_ST_FETCH || st == `CBD_ST_MEMRD);
  endsequence

  property p_ack_timing;
    s_ack_start ##1 (gate && aen_ok && !pas) |=> !irq_acknowledge_strobe_n;
  endproperty
  a_ack_timing: assert property (p_ack_timing) // R9
    else $error("acknowledge strobe late");

  property p_read_timing;
    s_read_start ##1 (gate && aen_ok && !pas) |=> !mem_read_strobe_n;
  endproperty
  a_read_timing: assert property (p_read_timing) // R9
    else $error("memory read strobe late");

  property p_den_read;
    !mem_read_strobe_n |-> xcvr_data_enable;
  endproperty
  a_den_read: assert property (p_den_read) // R11
    else $error("data enable low during memory read");

  // the shared pin follows the mode that decoded the strobe, hence the past value
  property p_peripheral_xcvr_enable;
    $past(mode) && !(io_read_strobe_n && early_io_write_strobe_n && irq_acknowledge_strobe_n)
      |-> !cascade_or_periph_enable_pin;
  endproperty
  a_peripheral_xcvr_enable: assert property (p_peripheral_xcvr_enable) // R15
    else $error("peripheral enable inactive during io command");

  property p_dir_latch;
    addr_latch_strobe && (r.cyc == `CBD_ST_IOWR || r.cyc == `CBD_ST_MEMWR)
      |-> xcvr_direction;
  endproperty
  a_dir_latch: assert property (p_dir_latch) // R18
    else $error("direction low at start of a write cycle");

  property p_float_io;
    aen_hi && mode |=> !mem_cmd_oe && io_cmd_oe;
  endproperty
  a_float_io: assert property (p_float_io) // R19
    else $error("wrong drivers floated in io bus mode");

  property p_latch_start;
    addr_latch_strobe |-> $past(r.ph) == CBD_IDLE ##1 !addr_latch_strobe;
  endproperty
  a_latch_start: assert property (p_latch_start) // R16
    else $error("latch strobe outside cycle start");

  property p_halt_quiet;
    r.cyc == `CBD_ST_HALT |-> all_cmd_idle && !xcvr_data_enable;
  endproperty
  a_halt_quiet: assert property (p_halt_quiet) // R1
    else $error("command during halt");

endmodule // cbd_top

// File: src/cbd_consts.svh
// timing, status codes and input-vector positions for the bus command decoder
`ifndef CBD_CONSTS_SVH
`define CBD_CONSTS_SVH
`define CBD_CLK_NS 10
`define CBD_AEN_NS 90
`define CBD_AEN_CYC ((`CBD_AEN_NS + `CBD_CLK_NS - 1) / `CBD_CLK_NS)
`define CBD_CNT_W 4
`define CBD_ST_IRQ_ACKNOWLEDGE_STROBE 3'h0
`define CBD_ST_IORD 3'h1
`define CBD_ST_IOWR 3'h2
`define CBD_ST_HALT 3'h3
`define CBD_ST_FETCH 3'h4
`define CBD_ST_MEMRD 3'h5
`define CBD_ST_MEMWR 3'h6
`define CBD_ST_PASSIVE 3'h7
`define CBD_IN_W 6
`define CBD_IX_AEN 3
`define CBD_IX_GATE 4
`define CBD_IX_MODE 5
`define CBD_IN_RST 6'h3F
`endif

// File: src/cbd_pkg.sv
// types for the bus command decoder
package cbd_pkg;
  typedef enum logic [1:0] {CBD_IDLE, CBD_LATCH, CBD_EARLY, CBD_FULL} cbd_phase_t;
  // registered outputs; command strobes are active low
  typedef struct packed {
    logic mem_read_strobe_n;
    logic mem_write_strobe_n;
    logic early_mem_write_strobe_n;
    logic io_read_strobe_n;
    logic io_write_strobe_n;
    logic early_io_write_strobe_n;
    logic irq_acknowledge_strobe_n;
    logic mem_cmd_oe;
    logic io_cmd_oe;
    logic xcvr_data_enable;
    logic xcvr_direction;
    logic cascade_or_periph_enable_pin;
    logic addr_latch_strobe;
  } cbd_out_t;
  typedef struct packed {
    logic [5:0] ff1;
    logic [5:0] ff2;
    logic [5:0] ff3;
    logic [5:0] fl;
    logic [3:0] aen_cnt;
    cbd_phase_t ph;
    logic [2:0] cyc;
    cbd_out_t o;
  } cbd_state_t;
endpackage

// File: sim/cbd_cpu_model.sv
// cpu status and bus arbiter model driving the decoder's input pins
`timescale 1ns/100ps

module cbd_cpu_model (
  // clock
  input wire logic clk,
  // cpu status pins
  output logic cpu_status_bit0_n,
  output logic cpu_status_bit1_n,
  output logic cpu_status_bit2_n,
  // arbiter grant, active low
  output logic arbiter_addr_enable_n
);
  // a released status bus reads passive through the pull-ups
  logic [2:0] status = 3'h7;

  assign {cpu_status_bit2_n, cpu_status_bit1_n, cpu_status_bit0_n} = status;

  initial begin
    arbiter_addr_enable_n = 1'b0;
  end

  // status changes just after an edge; the caller decides how long it stands
  task drive(input logic [2:0] c);
    @(posedge clk);
    status <= c;
  endtask

  // the grant may be held off for any length of time
  task set_aen(input logic v);
    @(posedge clk);
    arbiter_addr_enable_n <= v;
  endtask
endmodule // cbd_cpu_model

// File: sim/tb_cpu_bus_command_decoder.sv
// self-checking bench for the bus command decoder
`timescale 1ns/100ps
`define CHK(a, e, m) begin n_tests++; if ((a) !== (e)) begin bad_count++; $display("BAD %0t %s", $time, m); end end

module tb_cpu_bus_command_decoder
  import cbd_pkg::*;
;
  logic clk;
  logic rst_n;
  logic command_gate;
  logic io_bus_mode_select;
  wire logic cpu_status_bit0_n;
  wire logic cpu_status_bit1_n;
  wire logic cpu_status_bit2_n;
  wire logic arbiter_addr_enable_n;
  logic mem_read_strobe_n;
  logic mem_write_strobe_n;
  logic early_mem_write_strobe_n;
  logic io_read_strobe_n;
  logic io_write_strobe_n;
  logic early_io_write_strobe_n;
  logic irq_acknowledge_strobe_n;
  logic mem_cmd_oe;
  logic io_cmd_oe;
  logic xcvr_data_enable;
  logic xcvr_direction;
  logic cascade_or_periph_enable_pin;
  logic addr_latch_strobe;
  logic [6:0] cmd;
  // far-side flags: vector answer and cascade capture seen in this machine cycle
  logic vector_seen = 1'b0;
  logic cascade_seen = 1'b0;
  int bad_count = 0;
  int n_tests = 0;

  assign cmd = {mem_read_strobe_n, mem_write_strobe_n, early_mem_write_strobe_n,
    io_read_strobe_n, io_write_strobe_n, early_io_write_strobe_n, irq_acknowledge_strobe_n};

  cbd_cpu_model u_cbd_cpu_model (.clk(clk), .cpu_status_bit0_n(cpu_status_bit0_n),
    .cpu_status_bit1_n(cpu_status_bit1_n), .cpu_status_bit2_n(cpu_status_bit2_n),
    .arbiter_addr_enable_n(arbiter_addr_enable_n));

  cbd_top u_cbd_top (.clk(clk), .rst_n(rst_n), .cpu_status_bit0_n(cpu_status_bit0_n),
    .cpu_status_bit1_n(cpu_status_bit1_n), .cpu_status_bit2_n(cpu_status_bit2_n),
    .arbiter_addr_enable_n(arbiter_addr_enable_n),
    .command_gate(command_gate), .io_bus_mode_select(io_bus_mode_select),
    .mem_read_strobe_n(mem_read_strobe_n), .mem_write_strobe_n(mem_write_strobe_n),
    .early_mem_write_strobe_n(early_mem_write_strobe_n),
    .io_read_strobe_n(io_read_strobe_n), .io_write_strobe_n(io_write_strobe_n),
    .early_io_write_strobe_n(early_io_write_strobe_n),
    .irq_acknowledge_strobe_n(irq_acknowledge_strobe_n),
    .mem_cmd_oe(mem_cmd_oe), .io_cmd_oe(io_cmd_oe),
    .xcvr_data_enable(xcvr_data_enable), .xcvr_direction(xcvr_direction),
    .cascade_or_periph_enable_pin(cascade_or_periph_enable_pin),
    .addr_latch_strobe(addr_latch_strobe));

  // interrupting device answers the acknowledge; slave controller takes the cascade address
  always @(posedge clk) begin
    if (addr_latch_strobe) begin
      vector_seen <= 1'b0;
      cascade_seen <= 1'b0;
    end else begin
      if (!irq_acknowledge_strobe_n) begin
        vector_seen <= 1'b1;
      end
      if (cascade_or_periph_enable_pin && !io_bus_mode_select) begin
        cascade_seen <= 1'b1;
      end
    end
  end

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // strobes {mrd, mwr, emwr, iord, iowr, eiowr, ack}; early stage lacks the normal writes
  function automatic logic [6:0] exp_cmd(input logic [2:0] c, input logic early);
    case (c)
      3'h0: exp_cmd = 7'h7E;
      3'h1: exp_cmd = 7'h77;
      3'h2: exp_cmd = early ? 7'h7D : 7'h79;
      3'h4, 3'h5: exp_cmd = 7'h3F;
      3'h6: exp_cmd = early ? 7'h6F : 7'h4F;
      default: exp_cmd = 7'h7F;
    endcase
  endfunction

  task summarize;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // sample just after an edge so registered outputs have settled
  task edges(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // mode and gate pass the input synchronisers before they count
  task setup(input logic m, input logic g);
    @(posedge clk);
    io_bus_mode_select <= m;
    command_gate <= g;
    edges(6);
  endtask

  task automatic run_cycle(input logic [2:0] c, input logic m);
    logic wr, io;
    wr = (c == 3'h2) || (c == 3'h6);
    io = (c <= 3'h2);
    setup(m, 1'b1);
    u_cbd_cpu_model.drive(c);
    edges(5);
    `CHK(addr_latch_strobe, c != 3'h7, "latch strobe")
    `CHK(xcvr_direction, wr, "direction")
    edges(1);
    `CHK(addr_latch_strobe, 1'b0, "latch width")
    `CHK(cmd, exp_cmd(c, 1'b1), "early strobes")
    `CHK(xcvr_data_enable, m ? (c >= 3'h4 && c != 3'h7) : (c != 3'h3 && c != 3'h7), "den")
    `CHK(cascade_or_periph_enable_pin, m ? !io : (c == 3'h0), "shared pin")
    edges(1);
    `CHK(cmd, exp_cmd(c, 1'b0), "full strobes")
    `CHK(vector_seen, c == 3'h0, "vector answer")
    `CHK(cascade_seen, c == 3'h0 && !m, "cascade capture")
    u_cbd_cpu_model.drive(3'h7);
    edges(5);
    `CHK(cmd, 7'h7F, "cycle end")
    `CHK(xcvr_direction, 1'b0, "direction idle")
  endtask

  task automatic t_aen;
    int n;
    setup(1'b0, 1'b1);
    u_cbd_cpu_model.set_aen(1'b1);
    edges(5);
    u_cbd_cpu_model.drive(3'h5);
    edges(6);
    `CHK({cmd, mem_cmd_oe, io_cmd_oe}, 9'h1FC, "aen high blocks")
    u_cbd_cpu_model.set_aen(1'b0);
    n = 0;
    // the read is pending; count edges until the grant lets it out
    while (mem_read_strobe_n !== 1'b0 && n < 30) begin
      edges(1);
      n++;
    end
    `CHK(n >= 9 && n <= 16, 1'b1, "aen wait")
    `CHK(mem_cmd_oe, 1'b1, "mem oe")
    u_cbd_cpu_model.drive(3'h7);
    edges(4);
    setup(1'b1, 1'b1);
    u_cbd_cpu_model.set_aen(1'b1);
    edges(5);
    u_cbd_cpu_model.drive(3'h1);
    edges(6);
    `CHK({cmd, mem_cmd_oe, io_cmd_oe}, 9'h1DD, "io read with aen high")
    u_cbd_cpu_model.drive(3'h7);
    edges(4);
    u_cbd_cpu_model.drive(3'h5);
    edges(8);
    `CHK(mem_read_strobe_n, 1'b1, "mem read held")
    u_cbd_cpu_model.drive(3'h7);
    u_cbd_cpu_model.set_aen(1'b0);
    edges(16);
    $display("test aen done");
  endtask

  task t_gate;
    setup(1'b0, 1'b0);
    u_cbd_cpu_model.drive(3'h5);
    edges(6);
    `CHK({cmd, xcvr_data_enable, cascade_or_periph_enable_pin}, 9'h1FC, "gate low")
    @(posedge clk);
    command_gate <= 1'b1;
    edges(6);
    `CHK({cmd, xcvr_data_enable}, 8'h7F, "gate back")
    u_cbd_cpu_model.drive(3'h7);
    edges(4);
    setup(1'b1, 1'b0);
    u_cbd_cpu_model.drive(3'h1);
    edges(6);
    `CHK({cmd, cascade_or_periph_enable_pin}, 8'hFF, "gate low io")
    u_cbd_cpu_model.drive(3'h7);
    edges(4);
    $display("test gate done");
  endtask

  // every run takes well under a thousand cycles
  initial begin
    #20000;
    bad_count++;
    $display("BAD %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    command_gate = 1'b1;
    io_bus_mode_select = 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    edges(16);
    for (int m = 0; m < 2; m++) begin
      for (int c = 0; c < 8; c++) begin
        run_cycle(c[2:0], m[0]);
      end
    end
    $display("test decode done");
    t_aen();
    t_gate();
    summarize();
  end
endmodule // tb_cpu_bus_command_decoder
